/* File: hdl/hmsf_mailbox.sv */
`include "hmsf_cfg.svh"
`default_nettype none
module hmsf_mailbox (
   input  wire logic                       clk,
   input  wire logic                       reset,
   // host pins, asynchronous to clk
   input  wire logic                       host_cs_n,
   input  wire logic                       host_data_sel,
   input  wire logic                       host_addr2,
   input  wire logic                       host_iow_n,
   input  wire logic                       host_ior_n,
   // slave processor side, same clock
   input  wire logic                       slave_rd_in_data,
   input  wire logic                       slave_wr_out_data,
   input  wire logic                       slave_wr_status,
   input  wire logic [`HMSF_STATUS_W-1:0]  slave_status_wdata,
   // flags and status
   output logic                            inbound_full_flag,
   output logic                            outbound_full_flag,
   output logic                            command_data_marker,
   output logic                            user_defined_status_bit,
   output logic                            slave_irq,
   output logic [`HMSF_STATUS_W-1:0]       status_byte,
   // completed host data-register cycles, one clock each
   output logic                            host_data_write_done,
   output logic                            host_data_read_done
);
   logic [`HMSF_PIN_W-1:0] pins_async;
   logic [`HMSF_PIN_W-1:0] pins_sync;
   logic                   cs_n_s;
   logic                   data_sel_s;
   logic                   addr2_s;
   logic                   iow_n_s;
   logic                   ior_n_s;

   // all host pins pass two flops before anything reads them
   assign pins_async[`HMSF_PIN_CS_N]     = host_cs_n;
   assign pins_async[`HMSF_PIN_DATA_SEL] = host_data_sel;
   assign pins_async[`HMSF_PIN_ADDR2]    = host_addr2;
   assign pins_async[`HMSF_PIN_IOW_N]    = host_iow_n;
   assign pins_async[`HMSF_PIN_IOR_N]    = host_ior_n;

   hmsf_sync u_sync (
      .clk        (clk),
      .reset      (reset),
      .pins_async (pins_async),
      .pins_sync  (pins_sync)
   );

   // named views of the synchronised pins
   assign cs_n_s     = pins_sync[`HMSF_PIN_CS_N];
   assign data_sel_s = pins_sync[`HMSF_PIN_DATA_SEL];
   assign addr2_s    = pins_sync[`HMSF_PIN_ADDR2];
   assign iow_n_s    = pins_sync[`HMSF_PIN_IOW_N];
   assign ior_n_s    = pins_sync[`HMSF_PIN_IOR_N];

   // host cycle tracker state
   hmsf_pkg::hmsf_cycle_t cycle_reg;
   hmsf_pkg::hmsf_cycle_t cycle_next;
   logic                  sel_reg;
   logic                  sel_next;
   logic                  addr2_reg;
   logic                  addr2_next;
   logic                  wr_done_reg;
   logic                  wr_done_next;
   logic                  rd_done_reg;
   logic                  rd_done_next;

   // a cycle counts only when its strobe rises again, so the
   // address qualifiers are held from the strobe's falling edge;
   // a strobe that falls with chip select high is ignored
   always_comb
   begin
      cycle_next   = cycle_reg;
      sel_next     = sel_reg;
      addr2_next   = addr2_reg;
      wr_done_next = 1'b0;
      rd_done_next = 1'b0;
      unique case (cycle_reg)
         hmsf_pkg::HMSF_IDLE:
         begin
            if (!cs_n_s && !iow_n_s)
            begin
               cycle_next = hmsf_pkg::HMSF_WRITE;
               sel_next   = data_sel_s;
               addr2_next = addr2_s;
            end
            else if (!cs_n_s && !ior_n_s)
            begin
               cycle_next = hmsf_pkg::HMSF_READ;
               sel_next   = data_sel_s;
               addr2_next = addr2_s;
            end
         end
         hmsf_pkg::HMSF_WRITE:
         begin
            if (iow_n_s)
            begin
               cycle_next   = hmsf_pkg::HMSF_IDLE;
               wr_done_next = sel_reg;
            end
         end
         hmsf_pkg::HMSF_READ:
         begin
            if (ior_n_s)
            begin
               cycle_next   = hmsf_pkg::HMSF_IDLE;
               rd_done_next = sel_reg;
            end
         end
         default:
         begin
            cycle_next = hmsf_pkg::HMSF_IDLE;
         end
      endcase
   end

   // registers of the host cycle tracker
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cycle_reg   <= hmsf_pkg::HMSF_IDLE;
         sel_reg     <= `HMSF_RST_QUAL;
         addr2_reg   <= `HMSF_RST_QUAL;
         wr_done_reg <= 1'b0;
         rd_done_reg <= 1'b0;
      end
      else
      begin
         cycle_reg   <= cycle_next;
         sel_reg     <= sel_next;
         addr2_reg   <= addr2_next;
         wr_done_reg <= wr_done_next;
         rd_done_reg <= rd_done_next;
      end
   end

   // flag state
   logic inbound_reg;
   logic inbound_next;
   logic outbound_reg;
   logic outbound_next;
   logic marker_reg;
   logic marker_next;
   logic user_reg;
   logic user_next;
   logic out_clear;

   // slave may only clear the outbound flag; writing one does nothing
   assign out_clear = rd_done_reg
                    || (slave_wr_status && !slave_status_wdata[`HMSF_BIT_OUTBOUND_FULL]); // RULE_05

   // set terms sit last so a coincident clear loses
   always_comb
   begin
      inbound_next  = inbound_reg;
      outbound_next = outbound_reg;
      marker_next   = marker_reg;
      user_next     = user_reg;
      if (slave_rd_in_data)
      begin
         inbound_next = 1'b0; // RULE_03
      end
      if (wr_done_reg)
      begin
         inbound_next = 1'b1; // RULE_01 RULE_09
         marker_next  = addr2_reg; // RULE_08
      end
      if (out_clear)
      begin
         outbound_next = 1'b0; // RULE_05 RULE_06
      end
      if (slave_wr_out_data)
      begin
         outbound_next = 1'b1; // RULE_04 RULE_09
      end
      if (slave_wr_status)
      begin
         user_next = slave_status_wdata[`HMSF_BIT_USER]; // RULE_07
      end
   end

   // registers of the flags
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         inbound_reg  <= `HMSF_RST_FLAG;
         outbound_reg <= `HMSF_RST_FLAG; // RULE_06
         marker_reg   <= `HMSF_RST_FLAG;
         user_reg     <= `HMSF_RST_FLAG;
      end
      else
      begin
         inbound_reg  <= inbound_next;
         outbound_reg <= outbound_next;
         marker_reg   <= marker_next;
         user_reg     <= user_next;
      end
   end

   // status byte, unused bits read zero
   logic [`HMSF_STATUS_W-1:0] status_reg;
   logic [`HMSF_STATUS_W-1:0] status_next;

   // built from next values so the byte matches the flags every cycle
   always_comb
   begin
      status_next                          = '0;
      status_next[`HMSF_BIT_OUTBOUND_FULL] = outbound_next; // RULE_06
      status_next[`HMSF_BIT_INBOUND_FULL]  = inbound_next;
      status_next[`HMSF_BIT_USER]          = user_next;
      status_next[`HMSF_BIT_CMD_DATA]      = marker_next;
   end

   // register of the status byte
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         status_reg <= '0;
      end
      else
      begin
         status_reg <= status_next;
      end
   end

   // outputs, all from flops
   assign inbound_full_flag       = inbound_reg;
   assign outbound_full_flag      = outbound_reg;
   assign command_data_marker     = marker_reg;
   assign user_defined_status_bit = user_reg;
   assign slave_irq               = inbound_reg; // RULE_02
   assign status_byte             = status_reg;
   assign host_data_write_done    = wr_done_reg;
   assign host_data_read_done     = rd_done_reg;
endmodule
`default_nettype wire

/* File: hdl/hmsf_cfg.svh */
// Function
// RULE_01: A completed host I/O write to the host-to-slave data register sets the inbound flag.
// RULE_02: The inbound flag drives the slave interrupt request for as long as it is one.
// RULE_03: A slave read of the host-to-slave data register clears the inbound flag.
// RULE_04: A slave write of the slave-to-host data register sets the outbound flag.
// RULE_05: A host I/O read of slave-to-host data, or a slave write of zero, clears it.
// RULE_06: The outbound flag is status bit 0, resets to 0, and the slave may only clear it.
// RULE_07: A user status bit is freely set or cleared and touches no mailbox flag.
// RULE_08: Each host data write stores host address bit 2 as the command/data marker.
// RULE_09: When a flag is set and cleared in the same cycle, the set wins.
`ifndef HMSF_CFG_SVH
`define HMSF_CFG_SVH

// status byte layout
`define HMSF_BIT_OUTBOUND_FULL 0
`define HMSF_BIT_INBOUND_FULL  1
`define HMSF_BIT_USER          2
`define HMSF_BIT_CMD_DATA      3
`define HMSF_STATUS_W          8

// reset values
`define HMSF_RST_FLAG          1'b0
`define HMSF_RST_STROBE_N      1'b1
`define HMSF_RST_QUAL          1'b0

// host pin bundle positions inside the synchroniser
`define HMSF_PIN_CS_N          0
`define HMSF_PIN_DATA_SEL      1
`define HMSF_PIN_ADDR2         2
`define HMSF_PIN_IOW_N         3
`define HMSF_PIN_IOR_N         4
`define HMSF_PIN_W             5
`define HMSF_PIN_RST           5'h19

`endif

/* File: hdl/hmsf_pkg.sv */
`default_nettype none
package hmsf_pkg;
   // host bus cycle tracker
   typedef enum logic [1:0] {
      HMSF_IDLE,
      HMSF_WRITE,
      HMSF_READ
   } hmsf_cycle_t;
endpackage
`default_nettype wire

/* File: hdl/hmsf_sync.sv */
`include "hmsf_cfg.svh"
`default_nettype none
module hmsf_sync (
   input  wire logic                     clk,
   input  wire logic                     reset,
   input  wire logic [`HMSF_PIN_W-1:0]   pins_async,
   output logic      [`HMSF_PIN_W-1:0]   pins_sync
);
   logic [`HMSF_PIN_W-1:0] meta_reg;
   logic [`HMSF_PIN_W-1:0] meta_next;
   logic [`HMSF_PIN_W-1:0] stable_reg;
   logic [`HMSF_PIN_W-1:0] stable_next;

   // first stage feeds only the second stage
   always_comb
   begin
      meta_next   = pins_async;
      stable_next = meta_reg;
   end

   // reset to the idle pin levels so no false strobe edge appears
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         meta_reg   <= `HMSF_PIN_RST;
         stable_reg <= `HMSF_PIN_RST;
      end
      else
      begin
         meta_reg   <= meta_next;
         stable_reg <= stable_next;
      end
   end

   assign pins_sync = stable_reg;
endmodule
`default_nettype wire

/* File: testbench/hmsf_mailbox_checker.sv */
`include "hmsf_cfg.svh"
`default_nettype none
module hmsf_mailbox_checker (
   input wire logic                      clk,
   input wire logic                      reset,
   input wire logic                      host_cs_n,
   input wire logic                      host_data_sel,
   input wire logic                      host_addr2,
   input wire logic                      host_iow_n,
   input wire logic                      host_ior_n,
   input wire logic                      slave_rd_in_data,
   input wire logic                      slave_wr_out_data,
   input wire logic                      slave_wr_status,
   input wire logic [`HMSF_STATUS_W-1:0] slave_status_wdata,
   input wire logic                      inbound_full_flag,
   input wire logic                      outbound_full_flag,
   input wire logic                      command_data_marker,
   input wire logic                      user_defined_status_bit,
   input wire logic                      slave_irq,
   input wire logic [`HMSF_STATUS_W-1:0] status_byte,
   input wire logic                      host_data_write_done,
   input wire logic                      host_data_read_done
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // flag edges tied to their one-cycle causes, plus irq and status byte checked against the flags
   chk_irq_level: assert property (slave_irq == inbound_full_flag)
      else $error("irq differs from inbound flag");
   chk_in_set: assert property (host_data_write_done |=> inbound_full_flag)
      else $error("inbound flag not set");
   chk_in_clear: assert property (slave_rd_in_data && !host_data_write_done |=>
      !inbound_full_flag) else $error("inbound flag not cleared");
   chk_out_set: assert property (slave_wr_out_data |=> outbound_full_flag)
      else $error("outbound flag not set");
   chk_out_rdclr: assert property (host_data_read_done && !slave_wr_out_data |=>
      !outbound_full_flag) else $error("outbound flag kept after host read");
   chk_out_wrclr: assert property (slave_wr_status && !slave_status_wdata[0]
      && !slave_wr_out_data |=> !outbound_full_flag) else $error("zero write kept flag");
   chk_out_noset: assert property (!outbound_full_flag && !slave_wr_out_data |=>
      !outbound_full_flag) else $error("outbound flag rose without data write");
   chk_user_load: assert property (slave_wr_status |=>
      user_defined_status_bit == $past(slave_status_wdata[2])) else $error("user bit wrong");
   chk_status_map: assert property (status_byte == {4'h0, command_data_marker,
      user_defined_status_bit, inbound_full_flag, outbound_full_flag})
      else $error("status byte layout wrong");
   chk_marker_hold: assert property (!host_data_write_done |=>
      $stable(command_data_marker)) else $error("marker moved without host write");
   // collisions, and a zero status write to a full outbound flag, are the awkward corners worth seeing
   cover property (host_data_write_done && slave_rd_in_data);
   cover property (host_data_read_done && slave_wr_out_data);
   cover property (slave_wr_status && !slave_status_wdata[0] && outbound_full_flag);
endmodule
bind hmsf_mailbox hmsf_mailbox_checker i_chk (.*);
`default_nettype wire

/* File: testbench/hmsf_host_model.sv */
`default_nettype none
module hmsf_host_model (
   input wire logic clk,
   output logic     cs_n,
   output logic     data_sel,
   output logic     addr2,
   output logic     iow_n,
   output logic     ior_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle bus: not selected, no strobe
   initial
   begin
      cs_n = 1'b1;
      data_sel = 1'b0;
      addr2 = 1'b0;
      iow_n = 1'b1;
      ior_n = 1'b1;
   end
   // host strobes data or status, and can read or write either
   task xfer(input logic w, input logic s, input logic a);
      @(posedge clk);
      cs_n <= 1'b0;
      data_sel <= s;
      addr2 <= a;
      // strobe falls a clock later so select and address are settled first
      @(posedge clk);
      if (w)
         iow_n <= 1'b0;
      else
         ior_n <= 1'b0;
      repeat (4) @(posedge clk);
      iow_n <= 1'b1;
      ior_n <= 1'b1;
   endtask
   // released qualifiers flip so stale values cannot pass
   task rel;
      cs_n <= 1'b1;
      data_sel <= ~data_sel;
      addr2 <= ~addr2;
   endtask
endmodule
`default_nettype wire

/* File: testbench/host_mailbox_status_flags_tb_top.sv */
`default_nettype none
module host_mailbox_status_flags_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk = 1'b0;
   logic       reset;
   logic [2:0] sl;
   logic [7:0] wd;
   logic       e_in = 1'b0;
   logic       e_out = 1'b0;
   logic       e_usr = 1'b0;
   logic       e_cd = 1'b0;
   int         fails = 0;
   int         cmp_count = 0;
   wire logic  host_cs_n, host_data_sel, host_addr2, host_iow_n, host_ior_n;
   wire logic  in_f, out_f, cd, usr, irq, wdone, rdone;
   wire logic [7:0] stat;
   always #12.5 clk = ~clk;
   hmsf_host_model i_host (.clk(clk), .cs_n(host_cs_n), .data_sel(host_data_sel),
      .addr2(host_addr2), .iow_n(host_iow_n), .ior_n(host_ior_n));
   hmsf_mailbox i_dut (.clk(clk), .reset(reset), .host_cs_n(host_cs_n),
      .host_data_sel(host_data_sel), .host_addr2(host_addr2), .host_iow_n(host_iow_n),
      .host_ior_n(host_ior_n), .slave_rd_in_data(sl[2]), .slave_wr_out_data(sl[1]),
      .slave_wr_status(sl[0]), .slave_status_wdata(wd), .inbound_full_flag(in_f),
      .outbound_full_flag(out_f), .command_data_marker(cd), .user_defined_status_bit(usr),
      .slave_irq(irq), .status_byte(stat), .host_data_write_done(wdone),
      .host_data_read_done(rdone));
   task print_verdict;
      $display("fails=%0d cmp_count=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // every flag seen at own port and status byte; inbound also at irq
   task cmp_all;
      chk(stat, {4'h0, e_cd, e_usr, e_in, e_out});
      chk({4'h0, cd, usr, in_f, out_f}, {4'h0, e_cd, e_usr, e_in, e_out});
      chk({7'h0, irq}, {7'h0, e_in});
   endtask
   // slave pulse lands on the edge that also takes the done pulse
   task host(input logic w, input logic s, input logic a, input logic [2:0] p);
      i_host.xfer(w, s, a);
      repeat (3) @(posedge clk);
      sl <= p;
      #1 chk({7'h0, w ? wdone : rdone}, {7'h0, s});
      @(posedge clk);
      sl <= 3'h0;
      i_host.rel;
      #1 cmp_all;
   endtask
   task slv(input logic [2:0] p, input logic [7:0] d);
      @(posedge clk);
      sl <= p;
      wd <= d;
      @(posedge clk);
      sl <= 3'h0;
      #1 cmp_all;
   endtask
   initial
   begin
      repeat (3000) @(posedge clk);
      fails++;
      print_verdict;
   end
   initial
   begin
      reset = 1'b1;
      sl = 3'h0;
      wd = 8'h00;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      #1 cmp_all;
      {e_in, e_cd} = 2'h3;
      host(1'b1, 1'b1, 1'b1, 3'h0);
      e_in = 1'b0;
      slv(3'h4, 8'h00);
      {e_in, e_cd} = 2'h2;
      host(1'b1, 1'b1, 1'b0, 3'h4);
      host(1'b1, 1'b0, 1'b1, 3'h0);
      e_out = 1'b1;
      slv(3'h2, 8'h00);
      e_usr = 1'b1;
      slv(3'h1, 8'h05);
      {e_out, e_usr} = 2'h0;
      slv(3'h1, 8'h00);
      e_out = 1'b1;
      slv(3'h3, 8'h00);
      e_out = 1'b0;
      host(1'b0, 1'b1, 1'b0, 3'h0);
      e_out = 1'b1;
      host(1'b0, 1'b1, 1'b0, 3'h2);
      host(1'b0, 1'b0, 1'b0, 3'h0);
      {e_out, e_usr} = 2'h1;
      slv(3'h1, 8'hfe);
      e_usr = 1'b0;
      slv(3'h1, 8'h01);
      print_verdict;
   end
endmodule
`default_nettype wire
